// File: hdl/amps_pkg.sv
package amps_pkg;
    // core clock rate
    localparam int unsigned CLK_HZ = 100_000_000;
    // automatic mute hold before operating, in ms
    localparam int unsigned MUTE_HOLD_MS = 150;
    localparam int unsigned MUTE_HOLD_CYC = MUTE_HOLD_MS * (CLK_HZ / 1000);
    // over-current retry period, in ms
    localparam int unsigned RETRY_MS = 100;
    localparam int unsigned RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
    // internal carrier, in kHz
    localparam int unsigned CARRIER_KHZ = 350;
    localparam int unsigned CARRIER_DIV = CLK_HZ / (CARRIER_KHZ * 1000);
    localparam int unsigned DUTY_W = 8;
    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_FLAGS = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_DUTY1 = 4'h4;
    localparam logic [3:0] REG_DUTY2 = 4'h5;
    // interrupt flag positions
    localparam int unsigned IRQ_OVERTEMP = 0;
    localparam int unsigned IRQ_OVERCUR = 1;
    localparam int unsigned IRQ_SHORT = 2;
    localparam int unsigned IRQ_OPERATE = 3;
    localparam int unsigned IRQ_W = 4;
    // control register fields
    localparam int unsigned CTRL_EXT_OSC = 0;
    localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h80;
    // mode request encodings
    typedef enum logic [1:0] {
        AMPS_REQ_STANDBY = 2'h0,
        AMPS_REQ_MUTE = 2'h1,
        AMPS_REQ_OPERATE = 2'h2
    } amps_req_t;
    typedef enum logic [2:0] {
        AMPS_ST_STANDBY,
        AMPS_ST_SHORT_TEST,
        AMPS_ST_MUTE,
        AMPS_ST_MUTE_HOLD,
        AMPS_ST_OPERATE,
        AMPS_ST_OC_WAIT
    } amps_state_t;
endpackage

// File: hdl/amps_pwm_chan.sv
`timescale 1ns/1ns
`default_nettype none
// one pwm channel: compares carrier phase against duty, muted gives 50 %
module amps_pwm_chan #(
    parameter int unsigned DUTY_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic run,
    input wire logic pass_audio,
    input wire logic [DUTY_W-1:0] phase,
    input wire logic [DUTY_W-1:0] duty,
    output logic pwm_out
);
    wire logic [DUTY_W-1:0] eff_duty;
    wire logic next_pwm;

    assign eff_duty = pass_audio ? duty : {1'b1, {(DUTY_W-1){1'b0}}};
    assign next_pwm = run && (phase < eff_duty);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_out <= 1'b0;
        end else if (clk_en) begin
            pwm_out <= next_pwm;
        end
    end
endmodule // amps_pwm_chan
`default_nettype wire

// File: hdl/amps_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - The mode request selects standby, mute or operating.
// - In standby the channels are idle and the power stage is off.
// - In mute both channels switch but carry no audio.
// - In operating both channels switch and carry the audio.
// - An operating request first holds mute for 150 ms.
// - Outputs are PWM at about 350 kHz from the internal carrier.
// - With external oscillator selected the external clock paces the carrier.
// - Over-temperature stops the power stage at once.
// - Switching resumes only when the sensor reports cooled below the low point.
// - Over-current shuts the power stage off within one cycle.
// - After over-current a restart is tried every 100 ms.
// - Leaving standby, the outputs are checked for shorts before enabling.
// - A found short halts start-up until the outputs read open.
// - The short check runs only at start-up; later only over-current counts.
module amps_sequencer #(
    parameter int unsigned MUTE_HOLD_CYC = amps_pkg::MUTE_HOLD_CYC,
    parameter int unsigned RETRY_CYC = amps_pkg::RETRY_CYC,
    parameter int unsigned CARRIER_DIV = amps_pkg::CARRIER_DIV,
    parameter int unsigned DUTY_W = amps_pkg::DUTY_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [1:0] mode_req,
    input wire logic ext_osc_tick,
    input wire logic overtemp_hot,
    input wire logic temp_cooled,
    input wire logic overcurrent,
    input wire logic out_short,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic power_stage_en,
    output logic channel_one_pwm_output,
    output logic channel_two_pwm_output
);
    localparam int unsigned CNT_MAX = MUTE_HOLD_CYC > RETRY_CYC ? MUTE_HOLD_CYC : RETRY_CYC;
    localparam int unsigned CNT_W = $clog2(CNT_MAX) + 1;
    // carrier phase accumulator: fraction bits below the duty-wide phase
    localparam int unsigned ACC_W = 3 * DUTY_W;
    localparam int unsigned PHASE_STEP = (1 << ACC_W) / CARRIER_DIV;

    amps_pkg::amps_state_t state;
    amps_pkg::amps_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic thermal_trip;
    logic [ACC_W-1:0] phase_acc;
    logic [DUTY_W-1:0] phase;
    logic ext_osc_sel;
    logic [DUTY_W-1:0] duty1;
    logic [DUTY_W-1:0] duty2;
    logic [amps_pkg::IRQ_W-1:0] irq_flags;
    logic [amps_pkg::IRQ_W-1:0] irq_mask;
    logic short_seen;

    wire logic req_standby;
    wire logic req_operate;
    wire logic in_mute;
    wire logic run;
    wire logic pass_audio;
    wire logic carrier_tick;
    wire logic stage_state;
    wire logic sensors_ok;
    wire logic cnt_done_hold;
    wire logic cnt_done_retry;
    wire logic [amps_pkg::IRQ_W-1:0] irq_events;
    wire logic sel_ctrl;
    wire logic sel_status;
    wire logic sel_flags;
    wire logic sel_mask;
    wire logic sel_duty1;
    wire logic sel_duty2;
    wire logic [31:0] status_word;
    wire logic [amps_pkg::IRQ_W-1:0] flag_clr;
    wire logic [amps_pkg::IRQ_W-1:0] next_flags;
    wire logic enter_oc;
    wire logic enter_operate;
    wire logic wr_ctrl;
    wire logic wr_mask;
    wire logic wr_duty1;
    wire logic wr_duty2;
    logic [31:0] next_rdata;

    assign req_standby = (mode_req == amps_pkg::AMPS_REQ_STANDBY);
    assign req_operate = (mode_req == amps_pkg::AMPS_REQ_OPERATE);
    assign in_mute = (state == amps_pkg::AMPS_ST_MUTE) || (state == amps_pkg::AMPS_ST_MUTE_HOLD);
    assign stage_state = in_mute || (state == amps_pkg::AMPS_ST_OPERATE);
    // power stage cut combinationally by either sensor
    assign sensors_ok = !thermal_trip && !overtemp_hot && !overcurrent;
    assign run = stage_state && sensors_ok;
    assign pass_audio = (state == amps_pkg::AMPS_ST_OPERATE);
    assign power_stage_en = run;
    // internal carrier steps every cycle, external only on its ticks
    assign carrier_tick = ext_osc_sel ? ext_osc_tick : 1'b1;
    assign phase = phase_acc[ACC_W-1 -: DUTY_W];
    assign cnt_done_hold = (cnt >= CNT_W'(MUTE_HOLD_CYC - 1));
    assign cnt_done_retry = (cnt >= CNT_W'(RETRY_CYC - 1));

    // mode sequencing
    always_comb begin
        next_state = state;
        next_cnt = cnt + CNT_W'(1);
        case (state)
            amps_pkg::AMPS_ST_STANDBY: begin
                next_cnt = '0;
                if (!req_standby) begin
                    next_state = amps_pkg::AMPS_ST_SHORT_TEST;
                end
            end
            amps_pkg::AMPS_ST_SHORT_TEST: begin
                next_cnt = '0;
                if (req_standby) begin
                    next_state = amps_pkg::AMPS_ST_STANDBY;
                end else if (!out_short) begin
                    next_state = amps_pkg::AMPS_ST_MUTE;
                end
            end
            amps_pkg::AMPS_ST_MUTE: begin
                next_cnt = '0;
                if (req_standby) begin
                    next_state = amps_pkg::AMPS_ST_STANDBY;
                end else if (overcurrent) begin
                    next_state = amps_pkg::AMPS_ST_OC_WAIT;
                end else if (req_operate && !thermal_trip) begin
                    next_state = amps_pkg::AMPS_ST_MUTE_HOLD;
                end
            end
            amps_pkg::AMPS_ST_MUTE_HOLD: begin
                if (req_standby) begin
                    next_state = amps_pkg::AMPS_ST_STANDBY;
                end else if (overcurrent) begin
                    next_state = amps_pkg::AMPS_ST_OC_WAIT;
                    next_cnt = '0;
                end else if (!req_operate || thermal_trip) begin
                    next_state = amps_pkg::AMPS_ST_MUTE;
                end else if (cnt_done_hold) begin
                    next_state = amps_pkg::AMPS_ST_OPERATE;
                end
            end
            amps_pkg::AMPS_ST_OPERATE: begin
                next_cnt = '0;
                if (req_standby) begin
                    next_state = amps_pkg::AMPS_ST_STANDBY;
                end else if (overcurrent) begin
                    next_state = amps_pkg::AMPS_ST_OC_WAIT;
                end else if (!req_operate || thermal_trip) begin
                    next_state = amps_pkg::AMPS_ST_MUTE;
                end
            end
            amps_pkg::AMPS_ST_OC_WAIT: begin
                if (req_standby) begin
                    next_state = amps_pkg::AMPS_ST_STANDBY;
                end else if (cnt_done_retry) begin
                    next_state = amps_pkg::AMPS_ST_MUTE;
                end
            end
            default: begin
                next_state = amps_pkg::AMPS_ST_STANDBY;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= amps_pkg::AMPS_ST_STANDBY;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // one timer serves the mute hold and the retry wait
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (clk_en) begin
            cnt <= next_cnt;
        end
    end

    // thermal latch with hysteresis
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_trip <= 1'b0;
        end else if (clk_en) begin
            if (overtemp_hot) begin
                thermal_trip <= 1'b1;
            end else if (temp_cooled) begin
                thermal_trip <= 1'b0;
            end
        end
    end

    // carrier phase
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_acc <= '0;
        end else if (clk_en) begin
            if (!run) begin
                phase_acc <= '0;
            end else if (carrier_tick) begin
                phase_acc <= phase_acc + ACC_W'(PHASE_STEP);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            logic pwm;
            amps_pwm_chan #(.DUTY_W(DUTY_W)) u_chan (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .run(run),
                .pass_audio(pass_audio),
                .phase(phase),
                .duty(g == 0 ? duty1 : duty2),
                .pwm_out(pwm)
            );
        end
    endgenerate
    assign channel_one_pwm_output = gen_chan[0].pwm;
    assign channel_two_pwm_output = gen_chan[1].pwm;

    // short seen while testing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            short_seen <= 1'b0;
        end else if (clk_en) begin
            short_seen <= (state == amps_pkg::AMPS_ST_SHORT_TEST) && out_short;
        end
    end

    assign irq_events[amps_pkg::IRQ_OVERTEMP] = overtemp_hot && !thermal_trip;
    assign enter_oc = (next_state == amps_pkg::AMPS_ST_OC_WAIT)
        && (state != amps_pkg::AMPS_ST_OC_WAIT);
    assign irq_events[amps_pkg::IRQ_OVERCUR] = enter_oc;
    assign irq_events[amps_pkg::IRQ_SHORT] = (state == amps_pkg::AMPS_ST_SHORT_TEST)
        && out_short && !short_seen;
    assign enter_operate = (next_state == amps_pkg::AMPS_ST_OPERATE)
        && (state != amps_pkg::AMPS_ST_OPERATE);
    assign irq_events[amps_pkg::IRQ_OPERATE] = enter_operate;

    // register decode
    assign sel_ctrl = (reg_addr == amps_pkg::REG_CTRL);
    assign sel_status = (reg_addr == amps_pkg::REG_STATUS);
    assign sel_flags = (reg_addr == amps_pkg::REG_IRQ_FLAGS);
    assign sel_mask = (reg_addr == amps_pkg::REG_IRQ_MASK);
    assign sel_duty1 = (reg_addr == amps_pkg::REG_DUTY1);
    assign sel_duty2 = (reg_addr == amps_pkg::REG_DUTY2);
    assign wr_ctrl = reg_wr && sel_ctrl;
    assign wr_mask = reg_wr && sel_mask;
    assign wr_duty1 = reg_wr && sel_duty1;
    assign wr_duty2 = reg_wr && sel_duty2;
    assign flag_clr = (reg_wr && sel_flags) ? reg_wdata[amps_pkg::IRQ_W-1:0] : '0;
    assign status_word = {24'h0, power_stage_en, thermal_trip, pass_audio, 2'h0, 3'(state)};
    assign irq = |(irq_flags & irq_mask);

    // set wins over write-one-to-clear
    generate
        for (g = 0; g < amps_pkg::IRQ_W; g++) begin : gen_flag
            assign next_flags[g] = irq_events[g] || (irq_flags[g] && !flag_clr[g]);
        end
    endgenerate

    // read mux
    always_comb begin
        if (sel_ctrl) begin
            next_rdata = {31'h0, ext_osc_sel};
        end else if (sel_status) begin
            next_rdata = status_word;
        end else if (sel_flags) begin
            next_rdata = {28'h0, irq_flags};
        end else if (sel_mask) begin
            next_rdata = {28'h0, irq_mask};
        end else if (sel_duty1) begin
            next_rdata = {24'h0, duty1};
        end else if (sel_duty2) begin
            next_rdata = {24'h0, duty2};
        end else begin
            next_rdata = 32'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_osc_sel <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
            ext_osc_sel <= reg_wdata[amps_pkg::CTRL_EXT_OSC];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= '0;
        end else if (clk_en && wr_mask) begin
            irq_mask <= reg_wdata[amps_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            duty1 <= amps_pkg::DUTY_RESET;
        end else if (clk_en && wr_duty1) begin
            duty1 <= reg_wdata[DUTY_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            duty2 <= amps_pkg::DUTY_RESET;
        end else if (clk_en && wr_duty2) begin
            duty2 <= reg_wdata[DUTY_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags <= '0;
        end else if (clk_en) begin
            irq_flags <= next_flags;
        end
    end

    // zero outside the cycle after a read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end
endmodule // amps_sequencer
`default_nettype wire

// File: sim/amps_checker.sv
`timescale 1ns/1ns
`default_nettype none
module amps_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode_req,
    input wire logic overtemp_hot,
    input wire logic temp_cooled,
    input wire logic overcurrent,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic power_stage_en,
    input wire logic channel_one_pwm_output,
    input wire logic channel_two_pwm_output
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    standby_off_a: assert property ((mode_req == 2'h0)[*2] |=> !power_stage_en)
        else $error("stage on in standby");
    pwm_idle_a: assert property ((mode_req == 2'h0)[*3] |=>
        !channel_one_pwm_output && !channel_two_pwm_output)
        else $error("pwm active in standby");
    overtemp_off_a: assert property (overtemp_hot |-> !power_stage_en)
        else $error("stage on while hot");
    cool_wait_a: assert property ($fell(overtemp_hot) && !temp_cooled |-> !power_stage_en)
        else $error("stage on before cooled");
    overcur_off_a: assert property (overcurrent |-> !power_stage_en)
        else $error("stage on during overcurrent");
    retry_gap_a: assert property ($rose(overcurrent) |=> (!power_stage_en)[*8])
        else $error("retry too early");
    mask_off_a: assert property (reg_wr && reg_addr == amps_pkg::REG_IRQ_MASK &&
        reg_wdata[3:0] == 4'h0 |=> !irq)
        else $error("irq with empty mask");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data without read");
    cover property ($rose(power_stage_en));
    cover property ($rose(irq));
    cover property ($rose(overcurrent));
endmodule // amps_checker
bind amps_sequencer amps_checker amps_checker_i (.core_clk, .rst_n, .mode_req, .overtemp_hot,
    .temp_cooled, .overcurrent, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .power_stage_en, .channel_one_pwm_output, .channel_two_pwm_output);
`default_nettype wire

// File: sim/amps_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
module amps_stage_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic power_stage_en,
    input wire logic inject_oc,
    input wire logic inject_short,
    output logic overcurrent,
    output logic out_short,
    output logic ext_osc_tick
);
    logic [1:0] div;
    // current only flows while the stage drives the load
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overcurrent <= 1'b0;
            div <= 2'h0;
        end else begin
            overcurrent <= inject_oc & power_stage_en;
            div <= div + 2'h1;
        end
    end
    assign out_short = inject_short;
    // shared carrier source, one tick every four cycles
    assign ext_osc_tick = (div == 2'h3);
endmodule // amps_stage_model
`default_nettype wire

// File: sim/amps_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module amps_sequencer_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] mode_req = 2'h0;
    logic overtemp_hot = 1'b0;
    logic temp_cooled = 1'b1;
    logic inject_oc = 1'b0;
    logic inject_short = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] reg_rdata;
    logic irq, pse, ch1, ch2, overcurrent, out_short, tick;
    int n_errors = 0;
    int checks_done = 0;
    logic [31:0] d;
    int n, ti, te;
    always #5 core_clk = ~core_clk;
    amps_sequencer #(.MUTE_HOLD_CYC(20), .RETRY_CYC(30), .CARRIER_DIV(16)) amps_sequencer_i (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .mode_req(mode_req),
        .ext_osc_tick(tick), .overtemp_hot(overtemp_hot), .temp_cooled(temp_cooled),
        .overcurrent(overcurrent), .out_short(out_short), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .power_stage_en(pse), .channel_one_pwm_output(ch1),
        .channel_two_pwm_output(ch2));
    amps_stage_model amps_stage_model_i (.core_clk(core_clk), .rst_n(rst_n),
        .power_stage_en(pse), .inject_oc(inject_oc), .inject_short(inject_short),
        .overcurrent(overcurrent), .out_short(out_short), .ext_osc_tick(tick));
    task automatic summarize();
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        cyc(1);
    endtask
    // sel 0 watches the power stage, 1 the interrupt line
    task automatic wait_for(input int sel, input logic v, input int max, output int c);
        c = 0;
        while (((sel == 0) ? pse : irq) !== v) begin
            cyc(1);
            c++;
            if (c > max) begin
                n_errors++;
                summarize();
            end
        end
    endtask
    task automatic toggles(input int c, output int t);
        logic p;
        t = 0;
        p = ch1;
        repeat (c) begin
            cyc(1);
            if (ch1 !== p) t++;
            p = ch1;
        end
    endtask
    task automatic t_regs();
        rd(amps_pkg::REG_CTRL, d);
        chk("ctrl", 32'h0, d);
        rd(amps_pkg::REG_IRQ_MASK, d);
        chk("mask", 32'h0, d);
        rd(amps_pkg::REG_DUTY1, d);
        chk("duty1", {24'h0, amps_pkg::DUTY_RESET}, d);
        rd(amps_pkg::REG_DUTY2, d);
        chk("duty2", {24'h0, amps_pkg::DUTY_RESET}, d);
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, d);
        chk("unmapped", 32'h0, d);
        rd(amps_pkg::REG_STATUS, d);
        chk("state", 32'h0, 32'(d[2:0]));
    endtask
    task automatic t_startup();
        inject_short <= 1'b1;
        mode_req <= amps_pkg::AMPS_REQ_MUTE;
        cyc(10);
        rd(amps_pkg::REG_STATUS, d);
        chk("test state", 32'h1, 32'(d[2:0]));
        chk("pse short", 32'h0, 32'(pse));
        rd(amps_pkg::REG_IRQ_FLAGS, d);
        chk("short flag", 32'h1, 32'(d[amps_pkg::IRQ_SHORT]));
        inject_short <= 1'b0;
        wait_for(0, 1'b1, 10, n);
        rd(amps_pkg::REG_STATUS, d);
        chk("mute state", 32'h2, 32'(d[2:0]));
        toggles(64, ti);
        chk("mute pwm", 32'h1, 32'(ti > 0));
        wr(amps_pkg::REG_IRQ_FLAGS, 32'hf);
    endtask
    task automatic t_operate();
        wr(amps_pkg::REG_IRQ_MASK, 32'h8);
        mode_req <= amps_pkg::AMPS_REQ_OPERATE;
        wait_for(1, 1'b1, 40, n);
        chk("hold len", 32'h1, 32'(n >= 20 && n <= 24));
        rd(amps_pkg::REG_STATUS, d);
        chk("op state", 32'h4, 32'(d[2:0]));
        chk("audio", 32'h1, 32'(d[5]));
        inject_short <= 1'b1;
        cyc(5);
        chk("pse short op", 32'h1, 32'(pse));
        inject_short <= 1'b0;
        wr(amps_pkg::REG_IRQ_FLAGS, 32'h8);
        chk("irq clear", 32'h0, 32'(irq));
        wr(amps_pkg::REG_IRQ_MASK, 32'h0);
    endtask
    task automatic t_osc();
        toggles(256, ti);
        wr(amps_pkg::REG_CTRL, 32'h1);
        toggles(256, te);
        chk("ext runs", 32'h1, 32'(te > 0));
        chk("ext slower", 32'h1, 32'(te < ti));
        wr(amps_pkg::REG_CTRL, 32'h0);
        clk_en <= 1'b0;
        toggles(32, ti);
        chk("frozen pwm", 32'h0, 32'(ti));
        clk_en <= 1'b1;
    endtask
    task automatic t_thermal();
        overtemp_hot <= 1'b1;
        temp_cooled <= 1'b0;
        #1;
        chk("hot off", 32'h0, 32'(pse));
        cyc(3);
        overtemp_hot <= 1'b0;
        cyc(5);
        chk("warm off", 32'h0, 32'(pse));
        rd(amps_pkg::REG_IRQ_FLAGS, d);
        chk("temp flag", 32'h1, 32'(d[amps_pkg::IRQ_OVERTEMP]));
        temp_cooled <= 1'b1;
        wait_for(0, 1'b1, 10, n);
        rd(amps_pkg::REG_STATUS, d);
        chk("delay again", 32'h1, 32'(d[2:0] != 3'h4));
        cyc(30);
        rd(amps_pkg::REG_STATUS, d);
        chk("op again", 32'h4, 32'(d[2:0]));
    endtask
    task automatic t_overcur();
        inject_oc <= 1'b1;
        wait_for(0, 1'b0, 5, n);
        chk("oc cut", 32'h1, 32'(n <= 2));
        wait_for(0, 1'b1, 40, n);
        chk("retry gap", 32'h1, 32'(n >= 29 && n <= 32));
        wait_for(0, 1'b0, 5, n);
        chk("retrip", 32'h0, 32'(pse));
        inject_oc <= 1'b0;
        wait_for(0, 1'b1, 40, n);
        cyc(2);
        rd(amps_pkg::REG_STATUS, d);
        chk("hold again", 32'h3, 32'(d[2:0]));
        rd(amps_pkg::REG_IRQ_FLAGS, d);
        chk("oc flag", 32'h1, 32'(d[amps_pkg::IRQ_OVERCUR]));
    endtask
    task automatic t_standby();
        mode_req <= 2'h3;
        cyc(2);
        rd(amps_pkg::REG_STATUS, d);
        chk("mode3 state", 32'h2, 32'(d[2:0]));
        mode_req <= amps_pkg::AMPS_REQ_STANDBY;
        cyc(4);
        chk("stby pse", 32'h0, 32'(pse));
        chk("stby pwm", 32'h0, 32'(ch1 | ch2));
        rd(amps_pkg::REG_STATUS, d);
        chk("stby state", 32'h0, 32'(d[2:0]));
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        cyc(1);
        t_regs();
        t_startup();
        t_operate();
        t_osc();
        t_thermal();
        t_overcur();
        t_standby();
        summarize();
    end
endmodule // amps_sequencer_tb
`default_nettype wire
